// file: tcem_chk_monitor.sv
`timescale 1ns/10ps
module tcem_chk #(
    parameter STAGES   = 5,
    parameter FAIL_CYC = 1024
) (
    input wire              CLK,
    input wire              RST,
    input wire              POS_STROBE,
    input wire              NEG_STROBE,
    input wire              ERR_FAST_N,
    input wire              ERR_STRETCH,
    input wire              POS_MISSING,
    input wire              NEG_MISSING,
    input wire [STAGES-1:0] SR_STATE
);
    reg [5:0]  since_q;
    reg [31:0] pidle_q;
    reg [31:0] nidle_q;
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            since_q <= 6'h3F;
            pidle_q <= 32'h0;
            nidle_q <= 32'h0;
        end else begin
            since_q <= !ERR_FAST_N ? 6'h00 : since_q + {5'h00, since_q != 6'h3F};
            pidle_q <= $fell(POS_STROBE) ? 32'h0 : pidle_q + 32'h1;
            nidle_q <= $fell(NEG_STROBE) ? 32'h0 : nidle_q + 32'h1;
        end
    end
    a_fast_one_cycle: assert property ($fell(ERR_FAST_N) |=> ERR_FAST_N) // fast pulse
        else $error("fast error held");
    a_stretch_min: assert property (since_q < 13 |-> ERR_STRETCH) // stretch length
        else $error("stretch short");
    a_stretch_max: assert property (ERR_STRETCH && ERR_FAST_N |-> since_q <= 50) // cap
        else $error("stretch long");
    a_sr_thermo: assert property (((SR_STATE + 1'b1) & SR_STATE) == 0) // legal states
        else $error("register state illegal");
    a_shift_step: assert property (SR_STATE != $past(SR_STATE) |-> // one step
        SR_STATE == {$past(SR_STATE), 1'b1} || SR_STATE == ($past(SR_STATE) >> 1))
        else $error("register step wrong");
    a_err_sat: assert property (!ERR_FAST_N |-> $stable(SR_STATE)
        && (SR_STATE == 0 || &SR_STATE)) else $error("error at wrong state");
    a_pos_miss: assert property (pidle_q == FAIL_CYC + 8 |-> POS_MISSING)
        else $error("pos flag missing");
    a_neg_miss: assert property (nidle_q == FAIL_CYC + 8 |-> NEG_MISSING)
        else $error("neg flag missing");
    c_full_err: cover property (!ERR_FAST_N && &SR_STATE);
    c_empty_err: cover property (!ERR_FAST_N && SR_STATE == 0);
    c_both_miss: cover property (POS_MISSING && NEG_MISSING);
endmodule // tcem_chk
bind tcem_monitor tcem_chk #(.STAGES(STAGES), .FAIL_CYC(FAIL_CYC)) u_tcem_chk (.CLK(CLK),
    .RST(RST), .POS_STROBE(POS_STROBE), .NEG_STROBE(NEG_STROBE), .ERR_FAST_N(ERR_FAST_N),
    .ERR_STRETCH(ERR_STRETCH), .POS_MISSING(POS_MISSING), .NEG_MISSING(NEG_MISSING),
    .SR_STATE(SR_STATE));

// file: tcem_defs.vh
`ifndef TCEM_DEFS_VH
`define TCEM_DEFS_VH

// Clock period in ns (25 MHz)
`define TCEM_CLK_NS          40
// Stretched error pulse: least 0.5 us, longest 2 us, typical 0.7 us
`define TCEM_STR_MIN_NS      500
`define TCEM_STR_MAX_NS      2000
`define TCEM_STR_TYP_NS      700
// Stretch length in cycles: typical figure, clamped into min..max
`define TCEM_STR_CYC         ((`TCEM_STR_TYP_NS + `TCEM_CLK_NS - 1) / `TCEM_CLK_NS)
`define TCEM_STR_MIN_CYC     ((`TCEM_STR_MIN_NS + `TCEM_CLK_NS - 1) / `TCEM_CLK_NS)
`define TCEM_STR_MAX_CYC     (`TCEM_STR_MAX_NS / `TCEM_CLK_NS)
// Default missing-pulse timeout in cycles
`define TCEM_FAIL_CYC        1024
// Register width and reset value
`define TCEM_STAGES          5
`define TCEM_SR_RST          5'h00

`endif

// file: tcem_line.sv
`timescale 1ns/10ps
module tcem_line (
    input  wire CLK,
    input  wire go,
    input  wire pol,
    output reg  pos = 1'b0,
    output reg  neg = 1'b0
);
    reg hold_q = 1'b0;
    // Two cycles high keeps the pulse visible through the synchroniser
    always @(posedge CLK) begin
        if (go) begin
            pos <= pol;
            neg <= !pol;
        end else if (!hold_q) begin
            pos <= 1'b0;
            neg <= 1'b0;
        end
        hold_q <= go;
    end
endmodule // tcem_line

// file: tcem_monitor.v
`timescale 1ns/10ps
`include "tcem_defs.vh"

module tcem_monitor #(
    parameter STAGES   = `TCEM_STAGES,
    parameter FAIL_CYC = `TCEM_FAIL_CYC
) (
    input  wire              CLK,
    input  wire              RST,
    input  wire              POS_STROBE,
    input  wire              NEG_STROBE,
    output reg               ERR_FAST_N,
    output reg               ERR_STRETCH,
    output reg               POS_MISSING,
    output reg               NEG_MISSING,
    output reg  [STAGES-1:0] SR_STATE
);
    // Work at full width, then cut the stretch length to the counter
    localparam [31:0] STR_CYC_W = `TCEM_STR_CYC;
    localparam [31:0] STR_LO_W  = `TCEM_STR_MIN_CYC;
    localparam [31:0] STR_HI_W  = `TCEM_STR_MAX_CYC;
    // Clamp the typical length into the legal window
    localparam [31:0] STR_LEN_W = (STR_CYC_W < STR_LO_W) ? STR_LO_W :
                                  (STR_CYC_W > STR_HI_W) ? STR_HI_W : STR_CYC_W;
    localparam [7:0]  STR_LEN   = STR_LEN_W[7:0];
    localparam [31:0] FAIL_LIM  = FAIL_CYC;

    wire              pos_ev;
    wire              neg_ev;
    wire              pos_only;
    wire              neg_only;
    wire              pos_over;
    wire              neg_under;
    reg  [STAGES-1:0] sr_q;
    reg  [STAGES-1:0] sr_d;
    reg               err_d;
    reg               err_n_d;
    reg  [7:0]        str_q;
    reg  [7:0]        str_d;
    reg               stretch_d;
    reg  [31:0]       pos_cnt_q;
    reg  [31:0]       pos_cnt_d;
    reg               pos_miss_d;
    reg  [31:0]       neg_cnt_q;
    reg  [31:0]       neg_cnt_d;
    reg               neg_miss_d;

    // Saturating timeout count, reloaded by a pulse
    function [31:0] tick;
        input [31:0] cnt;
        input        ev;
        begin
            if (ev)
                tick = 32'h0;
            else if (cnt < FAIL_LIM)
                tick = cnt + 32'h1;
            else
                tick = cnt;
        end
    endfunction

    // Counter has reached the timeout
    function timed_out;
        input [31:0] cnt;
        begin
            timed_out = (cnt >= FAIL_LIM);
        end
    endfunction

    // One more stage filled from the stage 1 end
    function [STAGES-1:0] fill_up;
        input [STAGES-1:0] cur;
        begin
            fill_up = {cur[STAGES-2:0], 1'b1};
        end
    endfunction

    // One more stage emptied from the stage 5 end
    function [STAGES-1:0] drain_down;
        input [STAGES-1:0] cur;
        begin
            drain_down = {1'b0, cur[STAGES-1:1]};
        end
    endfunction

    tcem_sync_edge u_pos (
        .CLK  (CLK),
        .RST  (RST),
        .din  (POS_STROBE),
        .fall (pos_ev)
    );

    tcem_sync_edge u_neg (
        .CLK  (CLK),
        .RST  (RST),
        .din  (NEG_STROBE),
        .fall (neg_ev)
    );

    // Both polarities in one cycle cannot occur on a real ternary line;
    // they cancel here so the register keeps its value.
    assign pos_only  = pos_ev & ~neg_ev;
    assign neg_only  = neg_ev & ~pos_ev;

    assign pos_over  = pos_only & sr_q[STAGES-1];
    assign neg_under = neg_only & ~sr_q[0];

    // Any start tolerated
    // Odd start contents shift and check like legal ones; some, such as 10100, never drain out
    always @* begin
        sr_d  = sr_q;
        err_d = pos_over | neg_under;
        if (pos_only && !pos_over) begin
            sr_d = fill_up(sr_q);
        end else if (neg_only && !neg_under) begin
            sr_d = drain_down(sr_q);
        end else begin
            sr_d = sr_q;
        end
    end

    always @* begin
        err_n_d = ~err_d;
    end

    // Length within window
    // A fresh error restarts the count; a burst reads as one long pulse
    always @* begin
        if (err_d) begin
            str_d     = STR_LEN - 8'h01;
            stretch_d = 1'b1;
        end else if (str_q != 8'h00) begin
            str_d     = str_q - 8'h01;
            stretch_d = 1'b1;
        end else begin
            str_d     = 8'h00;
            stretch_d = 1'b0;
        end
    end

    // Timeout set, pulse clears
    // Counters saturate at the limit, so a dead line never wraps the flag off
    always @* begin
        pos_cnt_d  = tick(pos_cnt_q, pos_ev);
        neg_cnt_d  = tick(neg_cnt_q, neg_ev);
        pos_miss_d = !pos_ev && timed_out(pos_cnt_d);
        neg_miss_d = !neg_ev && timed_out(neg_cnt_d);
    end

    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            sr_q     <= `TCEM_SR_RST;
            SR_STATE <= `TCEM_SR_RST;
        end else begin
            sr_q     <= sr_d;
            SR_STATE <= sr_d;
        end
    end

    // Registered so the pin never sees a combinational glitch
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            ERR_FAST_N <= 1'b1;
        end else begin
            ERR_FAST_N <= err_n_d;
        end
    end

    // Stretch counter and its output move together
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            str_q       <= 8'h00;
            ERR_STRETCH <= 1'b0;
        end else begin
            str_q       <= str_d;
            ERR_STRETCH <= stretch_d;
        end
    end

    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            pos_cnt_q   <= 32'h0;
            POS_MISSING <= 1'b0;
        end else begin
            pos_cnt_q   <= pos_cnt_d;
            POS_MISSING <= pos_miss_d;
        end
    end

    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            neg_cnt_q   <= 32'h0;
            NEG_MISSING <= 1'b0;
        end else begin
            neg_cnt_q   <= neg_cnt_d;
            NEG_MISSING <= neg_miss_d;
        end
    end
endmodule // tcem_monitor

// file: tcem_monitor_tb.sv
`timescale 1ns/10ps
`include "tcem_defs.vh"
module tcem_monitor_tb;
    reg         CLK = 1'b0;
    reg         RST = 1'b1;
    reg         go = 1'b0;
    reg         pol = 1'b0;
    wire        pos, neg, efn, est, pm, nm;
    wire [4:0]  sr;
    reg  [4:0]  exp_sr = 5'h00;
    reg  [31:0] seed = 32'h9171;
    reg         low;
    integer     n_fail = 0, checks = 0, i, n_hi, n_lo;
    localparam [5:0] STR_EXP = (`TCEM_STR_TYP_NS + `TCEM_CLK_NS - 1) / `TCEM_CLK_NS;
    always #20 CLK = ~CLK;
    tcem_line u_tcem_line (.CLK(CLK), .go(go), .pol(pol), .pos(pos), .neg(neg));
    tcem_monitor #(.FAIL_CYC(8)) u_tcem_monitor (.CLK(CLK), .RST(RST), .POS_STROBE(pos),
        .NEG_STROBE(neg), .ERR_FAST_N(efn), .ERR_STRETCH(est), .POS_MISSING(pm),
        .NEG_MISSING(nm), .SR_STATE(sr));
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    function [5:0] nxt(input [4:0] s, input p);
        if (p) nxt = s[4] ? {1'b1, s} : {1'b0, s[3:0], 1'b1};
        else nxt = !s[0] ? {1'b1, s} : {2'b00, s[4:1]};
    endfunction
    task chk(input [63:0] nam, input [5:0] got, input [5:0] want);
        begin
            checks = checks + 1;
            if (got !== want) begin
                n_fail = n_fail + 1;
                $display("[ERR] %0s exp %h got %h", nam, want, got);
            end
        end
    endtask
    task pulse(input p);
        reg [5:0] e;
        begin
            e = nxt(exp_sr, p);
            exp_sr = e[4:0];
            @(posedge CLK);
            pol <= p;
            go <= 1'b1;
            @(posedge CLK);
            go <= 1'b0;
            low = 1'b0;
            repeat (10) begin
                @(negedge CLK);
                if (efn !== 1'b1) low = 1'b1;
            end
            chk("sr", {1'b0, sr}, {1'b0, exp_sr});
            chk("err", {5'h00, low}, {5'h00, e[5]});
        end
    endtask
    task summarize;
        begin
            if (n_fail == 0 && checks > 0) $display("bench passed");
            else $display("bench failed");
            $finish;
        end
    endtask
    initial begin
        repeat (20) @(posedge CLK);
        RST <= 1'b0;
        for (i = 0; i < 6; i = i + 1) pulse(1'b0);
        for (i = 0; i < 7; i = i + 1) pulse(1'b1);
        for (i = 0; i < 80; i = i + 1) begin
            seed = xs(seed);
            pulse(seed[0]);
        end
        repeat (20) @(negedge CLK);
        chk("miss", {4'h0, pm, nm}, 6'h03);
        pulse(1'b1);
        chk("pmiss", {5'h00, pm}, 6'h00);
        pulse(1'b0);
        chk("nmiss", {5'h00, nm}, 6'h00);
        repeat (30) @(negedge CLK);
        chk("idle", {5'h00, est}, 6'h00);
        while (!exp_sr[4]) pulse(1'b1);
        @(posedge CLK);
        pol <= 1'b1;
        go <= 1'b1;
        @(posedge CLK);
        go <= 1'b0;
        n_hi = 0;
        n_lo = 0;
        repeat (60) begin
            @(negedge CLK);
            if (est === 1'b1) n_hi = n_hi + 1;
            if (efn !== 1'b1) n_lo = n_lo + 1;
        end
        chk("stretch", n_hi[5:0], STR_EXP);
        chk("fastw", n_lo[5:0], 6'h01);
        chk("sat", {1'b0, sr}, 6'h1F);
        summarize;
    end
    initial begin
        #100000;
        n_fail = n_fail + 1;
        summarize;
    end
endmodule // tcem_monitor_tb

// file: tcem_sync_edge.v
`timescale 1ns/10ps
`include "tcem_defs.vh"

// Two-flop synchroniser followed by a falling-edge detector
module tcem_sync_edge (
    input  wire CLK,
    input  wire RST,
    input  wire din,
    output reg  fall
);
    reg meta_q;
    reg sync_q;
    reg last_q;

    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
            fall   <= 1'b0;
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
            last_q <= sync_q;
            fall   <= last_q & ~sync_q;
        end
    end
endmodule // tcem_sync_edge
